// ===== core/pipe_mac_pkg.sv
package pipe_mac_pkg;
   // Register byte offsets (chosen map)
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] TXCTL_OFS  = 8'h04;
   localparam logic [7:0] TXDATA_OFS = 8'h08;
   localparam logic [7:0] COEFF_OFS  = 8'h0C;
   localparam logic [7:0] EQ_OFS     = 8'h10;
   localparam logic [7:0] RXSTAT_OFS = 8'h14;
   localparam logic [7:0] RXDATA_OFS = 8'h18;
   localparam logic [7:0] SIM_OFS    = 8'h1C;

   // CTRL fields
   localparam int PWR_LSB    = 0;
   localparam int RATE_LSB   = 2;
   localparam int MARGIN_LSB = 4;
   localparam int SWING_BIT  = 7;
   localparam int POL_BIT    = 8;
   localparam int DET_BIT    = 9;
   localparam int IDLE_BIT   = 10;
   localparam int COMPL_BIT  = 11;
   localparam int GEN3_BIT   = 12;

   // TXCTL fields; writing TXDATA launches one beat with these
   localparam int DATAK_LSB  = 0;
   localparam int SYNC_LSB   = 4;
   localparam int BLKST_LSB  = 8;
   localparam int SKIP_BIT   = 12;
   localparam int DEEMP_BIT  = 13;

   // EQ fields
   localparam int EVAL_BIT   = 0;
   localparam int INPROG_BIT = 1;
   localparam int PRESET_LSB = 4;
   localparam int LIMIT_LSB  = 8;

   localparam logic [31:0] CTRL_RST = 32'h0000_0480;
   localparam logic [1:0]  PWR_P1   = 2'h2;

   localparam logic [1:0] SYNC_OS   = 2'h1;
   localparam logic [1:0] SYNC_DATA = 2'h2;
   localparam logic [1:0] RATE_G1   = 2'h0;
   localparam logic [1:0] RATE_G2   = 2'h1;
   localparam logic [1:0] RATE_G3   = 2'h2;
   localparam logic [1:0] FB_INC    = 2'h1;
   localparam logic [1:0] FB_DEC    = 2'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/pipe_mac_phy_interface.sv
// Functional notes
// [RULE1] One control flag per transmit byte
// [RULE2] PHY sends compliance pattern, negative disparity
// [RULE3] PHY idles lanes during electrical idle request
// [RULE4] Detect request starts receiver detection or loopback
// [RULE5] Two-bit power state selects P0..P2
// [RULE6] Voltage margin from link control 2
// [RULE7] De-emphasis taken from partner training sets
// [RULE8] Swing high full, low half
// [RULE9] Sync header 01 ordered set, 10 data
// [RULE10] Block start marks new transmit block
// [RULE11] Data-skip low one clock drops data
// [RULE12] Rate 00 Gen1, 01 Gen2, 1X Gen3
// [RULE13] Polarity request inverts PHY receive decoder
// [RULE14] Coefficients pre 5:0, main 11:6, post 17:12
// [RULE15] Eval request, phystatus completes, drop aborts
// [RULE16] Invalid flag holds until next eval request
// [RULE17] PHY receive control flags per byte
// [RULE18] PHY status signals operation completion
// [RULE19] Receive valid only with symbol lock
// [RULE20] Receive data-skip low drops receive data
// [RULE21] Feedback two bits per cursor, inc/dec
// [RULE22] Simulation mode reports training state
// [RULE23] All interface signals synchronous to clock
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
module pipe_mac_phy_interface #(
   parameter int COEF_W = 6
) (
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Partner de-emphasis indication from training sets
   input  wire logic                ts_deemp,
   // PIPE transmit and control
   output logic [31:0]              txdata,
   output logic [3:0]               txdatak,
   output logic                     txcompl,
   output logic                     txelecidle,
   output logic                     txdetectrx,
   output logic [1:0]               powerdown,
   output logic [2:0]               txmargin,
   output logic                     txdeemp,
   output logic                     txswing,
   output logic [1:0]               txsynchd,
   output logic [3:0]               txblkst,
   output logic                     txdataskip,
   output logic [1:0]               rate,
   output logic                     rxpolarity,
   output logic [2:0]               currentrxpreset,
   output logic [3*COEF_W-1:0]      currentcoeff,
   output logic                     rxeqeval,
   output logic                     rxeqinprogress,
   output logic                     invalidreq,
   // PIPE receive
   input  wire logic [31:0]         rxdata,
   input  wire logic [3:0]          rxdatak,
   input  wire logic                phystatus,
   input  wire logic                rxvalid,
   input  wire logic [2:0]          rxstatus,
   input  wire logic                rxelecidle,
   input  wire logic [1:0]          rxsynchd,
   input  wire logic [3:0]          rxblkst,
   input  wire logic                rxdataskip,
   input  wire logic [5:0]          dirfeedback,
   // Simulation reporting
   input  wire logic                simu_mode_pipe,
   output logic [1:0]               sim_pipe_rate,
   output logic [5:0]               sim_ltssmstate
);

   ////////////////////////////////////////////////////////////////////////////////
   // Receive inputs: synchronous to the PIPE clock, so sampled directly
   logic [31:0]       ctrl_q;
   logic [31:0]       txctl_q;
   logic [31:0]       txword_q;
   logic              tx_launch_q;
   logic [3*COEF_W-1:0] coeff_q;
   logic [31:0]       eq_q;
   logic [31:0]       rxword_q;
   logic [15:0]       rxstat_q;
   logic              eval_done_q;
   logic              eval_abort_q;
   logic              inval_q;
   logic [5:0]        ltssm_q;

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data accepted in either order
   logic              aw_held_q, w_held_q;
   logic [7:0]        awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              wr_fire;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic known(input logic [7:0] a);
      // The map is dense and word aligned from the first to the last offset
      return a <= pipe_mac_pkg::SIM_OFS && a[1:0] == 2'h0;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= pipe_mac_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready;
         s_axi_wready  <= !w_held_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known(awaddr_q) ? pipe_mac_pkg::RESP_OKAY
                                            : pipe_mac_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q      <= pipe_mac_pkg::CTRL_RST;
         txctl_q     <= 32'h0000_1000;
         txword_q    <= 32'h0000_0000;
         tx_launch_q <= 1'b0;
         coeff_q     <= '0;
         eq_q        <= 32'h0000_0000;
         ltssm_q     <= 6'h00;
      end else begin
         tx_launch_q <= 1'b0;
         if (wr_fire) begin
            case (awaddr_q)
               pipe_mac_pkg::CTRL_OFS:   ctrl_q  <= merge(ctrl_q, wdata_q, wstrb_q);
               pipe_mac_pkg::TXCTL_OFS:  txctl_q <= merge(txctl_q, wdata_q, wstrb_q);
               pipe_mac_pkg::TXDATA_OFS: begin
                  txword_q    <= merge(txword_q, wdata_q, wstrb_q);
                  tx_launch_q <= 1'b1;
               end
               pipe_mac_pkg::COEFF_OFS:  coeff_q <= wdata_q[3*COEF_W-1:0];
               pipe_mac_pkg::EQ_OFS:     eq_q    <= merge(eq_q, wdata_q, wstrb_q);
               pipe_mac_pkg::SIM_OFS:    ltssm_q <= wdata_q[5:0];
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // PIPE transmit outputs, all registered on aclk [RULE23]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txdata     <= 32'h0000_0000;
         txdatak    <= 4'h0;
         txsynchd   <= 2'h0;
         txblkst    <= 4'h0;
         txdataskip <= 1'b1;
      end else if (tx_launch_q) begin
         txdata     <= txword_q;
         txdatak    <= txctl_q[pipe_mac_pkg::DATAK_LSB +: 4];               // [RULE1]
         // Gen3 headers only; zero when Gen3 is off
         txsynchd   <= ctrl_q[pipe_mac_pkg::GEN3_BIT]
                       ? txctl_q[pipe_mac_pkg::SYNC_LSB +: 2] : 2'h0;       // [RULE9]
         txblkst    <= ctrl_q[pipe_mac_pkg::GEN3_BIT]
                       ? txctl_q[pipe_mac_pkg::BLKST_LSB +: 4] : 4'h0;      // [RULE10]
         // Skip beat lasts exactly this one cycle
         txdataskip <= !(ctrl_q[pipe_mac_pkg::GEN3_BIT]
                         && txctl_q[pipe_mac_pkg::SKIP_BIT]);              // [RULE11]
      end else begin
         txblkst    <= 4'h0;                                                // [RULE10]
         txdataskip <= 1'b1;                                                // [RULE11]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txcompl    <= 1'b0;
         txelecidle <= 1'b1;
         txdetectrx <= 1'b0;
         powerdown  <= pipe_mac_pkg::PWR_P1;
         txmargin   <= 3'h0;
         txswing    <= 1'b1;
         rate       <= pipe_mac_pkg::RATE_G1;
         rxpolarity <= 1'b0;
         txdeemp    <= 1'b0;
      end else begin
         txcompl    <= ctrl_q[pipe_mac_pkg::COMPL_BIT];                     // [RULE2]
         txelecidle <= ctrl_q[pipe_mac_pkg::IDLE_BIT];                      // [RULE3]
         txdetectrx <= ctrl_q[pipe_mac_pkg::DET_BIT];                       // [RULE4]
         powerdown  <= ctrl_q[pipe_mac_pkg::PWR_LSB +: 2];                  // [RULE5]
         txmargin   <= ctrl_q[pipe_mac_pkg::MARGIN_LSB +: 3];               // [RULE6]
         txswing    <= ctrl_q[pipe_mac_pkg::SWING_BIT];                     // [RULE8]
         // Gen3 request folds to 2'b10 so the X bit is always defined
         rate       <= ctrl_q[pipe_mac_pkg::RATE_LSB + 1] ? pipe_mac_pkg::RATE_G3
                       : ctrl_q[pipe_mac_pkg::RATE_LSB +: 2];               // [RULE12]
         rxpolarity <= ctrl_q[pipe_mac_pkg::POL_BIT];                       // [RULE13]
         // Partner's training-set indication rules; software cannot override
         txdeemp    <= ts_deemp;                                            // [RULE7]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Equalization handshake and coefficients
   function automatic logic fb_bad(input logic [1:0] fb, input logic [COEF_W-1:0] c,
                                   input logic [COEF_W-1:0] lim);
      return (fb == pipe_mac_pkg::FB_INC && c >= lim) ||
             (fb == pipe_mac_pkg::FB_DEC && c == '0) || fb == 2'h3;
   endfunction

   logic fb_invalid;
   always_comb begin
      fb_invalid = 1'b0;
      for (int k = 0; k < 3; k++) begin
         fb_invalid = fb_invalid | fb_bad(dirfeedback[2*k +: 2], coeff_q[COEF_W*k +: COEF_W],
                                          eq_q[pipe_mac_pkg::LIMIT_LSB +: COEF_W]); // [RULE21]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxeqeval        <= 1'b0;
         rxeqinprogress  <= 1'b0;
         currentrxpreset <= 3'h0;
         currentcoeff    <= '0;
         invalidreq      <= 1'b0;
         eval_done_q     <= 1'b0;
         eval_abort_q    <= 1'b0;
         inval_q         <= 1'b0;
      end else begin
         currentcoeff    <= coeff_q;                                        // [RULE14]
         currentrxpreset <= eq_q[pipe_mac_pkg::PRESET_LSB +: 3];
         rxeqinprogress  <= eq_q[pipe_mac_pkg::INPROG_BIT];
         rxeqeval        <= eq_q[pipe_mac_pkg::EVAL_BIT] && !eval_done_q;   // [RULE15]
         // Completion seen while the request is up ends it
         if (rxeqeval && phystatus) begin
            eval_done_q <= 1'b1;                                            // [RULE18]
            rxeqeval    <= 1'b0;
            if (rxvalid && fb_invalid) begin                                // [RULE19]
               inval_q <= 1'b1;
            end
         end else if (!eq_q[pipe_mac_pkg::EVAL_BIT]) begin
            eval_done_q <= 1'b0;
            if (rxeqeval) begin
               eval_abort_q <= 1'b1;                                        // [RULE15]
            end
         end
         if (!rxeqeval && eq_q[pipe_mac_pkg::EVAL_BIT] && !eval_done_q) begin
            eval_abort_q <= 1'b0;
            inval_q      <= 1'b0;                                           // [RULE16]
         end
         invalidreq <= inval_q;                                             // [RULE16]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive capture: skipped cycles and unlocked data are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxword_q <= 32'h0000_0000;
         rxstat_q <= 16'h0000;
      end else begin
         if (rxvalid && rxdataskip) begin                                   // [RULE19] [RULE20]
            rxword_q <= rxdata;
            rxstat_q[3:0] <= rxdatak;                                       // [RULE17]
            rxstat_q[7:4] <= rxblkst;
            rxstat_q[9:8] <= rxsynchd;                                      // [RULE9]
         end
         rxstat_q[15:10] <= {phystatus, rxvalid, rxelecidle, rxstatus};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Simulation reporting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sim_pipe_rate  <= pipe_mac_pkg::RATE_G1;
         sim_ltssmstate <= 6'h00;
      end else if (simu_mode_pipe) begin                                    // [RULE22]
         sim_pipe_rate  <= rate;
         sim_ltssmstate <= ltssm_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= pipe_mac_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= known(s_axi_araddr) ? pipe_mac_pkg::RESP_OKAY
                                                 : pipe_mac_pkg::RESP_SLVERR;
            case (s_axi_araddr)
               pipe_mac_pkg::CTRL_OFS:   s_axi_rdata <= ctrl_q;
               pipe_mac_pkg::TXCTL_OFS:  s_axi_rdata <= {txctl_q[31:14], txdeemp,
                                                         txctl_q[12:0]};
               pipe_mac_pkg::TXDATA_OFS: s_axi_rdata <= txword_q;
               pipe_mac_pkg::COEFF_OFS:  s_axi_rdata <= {{(32-3*COEF_W){1'b0}}, coeff_q};
               pipe_mac_pkg::EQ_OFS:     s_axi_rdata <= {eq_q[31:16], 10'h000, dirfeedback};
               pipe_mac_pkg::RXSTAT_OFS: s_axi_rdata <= {13'h0000, invalidreq, eval_abort_q,
                                                         eval_done_q, rxstat_q};
               pipe_mac_pkg::RXDATA_OFS: s_axi_rdata <= rxword_q;
               pipe_mac_pkg::SIM_OFS:    s_axi_rdata <= {24'h00_0000, sim_pipe_rate,
                                                         sim_ltssmstate};
               default:                  s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ===== tb/pipe_mac_chk.sv
module pipe_mac_chk (
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Register bus read handshake
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   // PIPE side
   input wire logic       ts_deemp,
   input wire logic       txdeemp,
   input wire logic [3:0] txblkst,
   input wire logic       txdataskip,
   input wire logic [1:0] rate,
   input wire logic       rxeqeval,
   input wire logic       phystatus,
   input wire logic       invalidreq,
   input wire logic       simu_mode_pipe,
   input wire logic [1:0] sim_pipe_rate,
   input wire logic [5:0] sim_ltssmstate
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read answer");
   a_deemp_follow: assert property ($past(aresetn) |-> txdeemp == $past(ts_deemp))
      else $error("de-emphasis mismatch");
   a_blkst_pulse: assert property (txblkst != 4'h0 |=> txblkst == 4'h0)
      else $error("long block start");
   a_skip_pulse: assert property (!txdataskip |=> txdataskip)
      else $error("long data skip");
   a_rate_legal: assert property (rate != 2'h3)
      else $error("rate code 11 driven");
   a_eval_done: assert property (rxeqeval && phystatus |-> ##[1:2] !rxeqeval)
      else $error("eval held after done");
   a_invalid_hold: assert property ($past(aresetn) && $fell(invalidreq) |->
      rxeqeval || $past(rxeqeval))
      else $error("invalid flag dropped early");
   a_invalid_set: assert property ($past(aresetn) && $rose(invalidreq) |->
      $past(phystatus) || $past(phystatus, 2))
      else $error("invalid flag without done");
   a_sim_freeze: assert property ($past(aresetn) && !$past(simu_mode_pipe) |->
      $stable(sim_ltssmstate) && $stable(sim_pipe_rate))
      else $error("sim state moved");
endmodule

bind pipe_mac_phy_interface pipe_mac_chk pipe_mac_chk_i (.*);

// ===== tb/pipe_phy_model.sv
module pipe_phy_model (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Requests from the MAC
   input  wire logic [31:0] txdata,
   input  wire logic [3:0]  txdatak,
   input  wire logic [1:0]  txsynchd,
   input  wire logic [3:0]  txblkst,
   input  wire logic        txdataskip,
   input  wire logic        txelecidle,
   input  wire logic        txdetectrx,
   input  wire logic        rxpolarity,
   input  wire logic [1:0]  powerdown,
   input  wire logic        rxeqeval,
   // Behaviour chosen by the bench
   input  wire logic [3:0]  eval_wait,
   input  wire logic [5:0]  fb_code,
   // Receive side towards the MAC
   output logic [31:0]      rxdata,
   output logic [3:0]       rxdatak,
   output logic             phystatus,
   output logic             rxvalid,
   output logic [2:0]       rxstatus,
   output logic             rxelecidle,
   output logic [1:0]       rxsynchd,
   output logic [3:0]       rxblkst,
   output logic             rxdataskip,
   output logic [5:0]       dirfeedback
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] pd_q;
   logic       ev_q;
   logic       det_q;
   int         cnt = -1;

   ////////////////////////////////////////
   always @(posedge aclk) begin
      pd_q <= powerdown;
      ev_q <= rxeqeval;
      det_q <= txdetectrx;
      phystatus <= 1'b0;
      rxstatus <= 3'h0;
      rxvalid <= aresetn && !txelecidle;
      rxelecidle <= txelecidle;
      rxdata <= (txelecidle ? ~rxdata : txdata) ^ {32{rxpolarity}};
      rxdatak <= txdatak;
      rxsynchd <= txsynchd;
      rxblkst <= txblkst;
      rxdataskip <= txdataskip;
      if (powerdown != pd_q) begin
         phystatus <= 1'b1;
      end
      if (txdetectrx && !det_q) begin
         phystatus <= 1'b1;
         rxstatus <= 3'h3;
      end
      if (!rxeqeval) begin
         cnt <= -1;
      end else if (!ev_q) begin
         cnt <= int'(eval_wait);
         dirfeedback <= fb_code;
      end else if (cnt == 0) begin
         phystatus <= 1'b1;
         cnt <= -1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      if (!aresetn) begin
         rxdata <= 32'hA5A5_A5A5;
         dirfeedback <= 6'h00;
      end
   end
endmodule

// ===== tb/test_pipe_mac_phy_interface.sv
module test_pipe_mac_phy_interface;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, ts_deemp, txcompl, txelecidle, txdetectrx, txdeemp, txswing;
   logic        txdataskip, rxpolarity, rxeqeval, rxeqinprogress, invalidreq, phystatus;
   logic        rxvalid, rxelecidle, rxdataskip, simu_mode_pipe;
   logic [1:0]  s_axi_bresp, s_axi_rresp, powerdown, txsynchd, rate, rxsynchd, sim_pipe_rate;
   logic [2:0]  txmargin, currentrxpreset, rxstatus;
   logic [3:0]  s_axi_wstrb, txdatak, txblkst, rxdatak, rxblkst, eval_wait;
   logic [5:0]  dirfeedback, fb_code, sim_ltssmstate;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [17:0] currentcoeff;
   logic [31:0] s_axi_wdata, s_axi_rdata, txdata, rxdata;
   int          n_errors = 0;
   int          checks_done = 0;
   int          seed = 32'hc913e23d;
   int          cyc = 0;

   pipe_mac_phy_interface pipe_mac_phy_interface_i (.*);
   pipe_phy_model pipe_phy_model_i (.*);

   ////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   ////////////////////////////////////////
   initial begin
      logic [31:0] d, v, c, ctrl;
      logic [1:0]  r, rt;
      logic [3:0]  s;
      int          t;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ts_deemp, simu_mode_pipe} <= 5'h00;
      {s_axi_bready, s_axi_rready, aresetn} <= 3'b110;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} <= 52'h0;
      {eval_wait, fb_code} <= 10'h000;
      tk(2);
      aresetn <= 1'b1;
      tk(1);
      chk({txelecidle, powerdown, txswing, txdataskip, rate, txcompl},
          {1'b1, pipe_mac_pkg::PWR_P1, 2'b11, pipe_mac_pkg::RATE_G1, 1'b0});
      rd(pipe_mac_pkg::CTRL_OFS, d, r);
      chk(d, pipe_mac_pkg::CTRL_RST);
      $display("test reset done");
      ctrl = pipe_mac_pkg::CTRL_RST;
      for (int i = 0; i < 16; i++) begin
         v = $random(seed);
         v[3:0] = 4'(i);
         s = 4'($random(seed)) | 4'h1;
         wr(pipe_mac_pkg::CTRL_OFS, v, s, r);
         for (int b = 0; b < 4; b++) if (s[b]) ctrl[8*b+:8] = v[8*b+:8];
         rt = ctrl[3:2] == 2'h3 ? pipe_mac_pkg::RATE_G3 : ctrl[3:2];
         tk(3);
         chk({powerdown, rate, txmargin, txswing, rxpolarity, txdetectrx, txelecidle, txcompl},
             {ctrl[1:0], rt, ctrl[6:4], ctrl[7], ctrl[8], ctrl[9], ctrl[10], ctrl[11]});
      end
      wr(pipe_mac_pkg::CTRL_OFS, 32'h0000_1088, 4'hF, r);
      $display("test control done");
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         c = 32'($random(seed)) & 32'h0000_000F;
         c[5:4] = i[1] ? pipe_mac_pkg::SYNC_DATA : pipe_mac_pkg::SYNC_OS;
         c[11:8] = 4'h1 << i;
         c[12] = i[0];
         ts_deemp <= i[1];
         wr(pipe_mac_pkg::TXCTL_OFS, c, 4'hF, r);
         fork
            wr(pipe_mac_pkg::TXDATA_OFS, v, 4'hF, r);
            begin
               t = 0;
               while (txblkst === 4'h0 && t < 20) begin
                  @(posedge aclk);
                  t++;
               end
               chk({txdata, txdatak, txsynchd, txblkst, txdataskip},
                   {v, c[3:0], c[5:4], c[11:8], !c[12]});
            end
         join
         tk(2);
         chk(txdeemp, i[1]);
      end
      rd(pipe_mac_pkg::RXDATA_OFS, d, r);
      chk(d, v);
      $display("test transmit done");
      v = $random(seed);
      wr(pipe_mac_pkg::COEFF_OFS, v, 4'hF, r);
      tk(3);
      chk({r, currentcoeff[17:12], currentcoeff[11:6], currentcoeff[5:0]},
          {pipe_mac_pkg::RESP_OKAY, v[17:0]});
      for (int i = 0; i < 3; i++) begin
         fb_code <= (i == 1) ? 6'h30 : 6'h00;
         eval_wait <= (i == 2) ? 4'hF : 4'h3;
         wr(pipe_mac_pkg::EQ_OFS, {18'h0, 6'h20, 1'b0, 3'(i + 1), 4'h3}, 4'hF, r);
         tk(1);
         chk({rxeqeval, rxeqinprogress, currentrxpreset}, {2'b11, 3'(i + 1)});
         if (i == 2) wr(pipe_mac_pkg::EQ_OFS, 32'h0, 4'hF, r);
         t = 0;
         while (rxeqeval !== 1'b0 && t < 40) begin
            @(posedge aclk);
            t++;
         end
         tk(2);
         rd(pipe_mac_pkg::RXSTAT_OFS, d, r);
         chk({d[18], invalidreq, i == 2 ? d[17] : d[16]}, {i == 1, i == 1, 1'b1});
         wr(pipe_mac_pkg::EQ_OFS, 32'h0, 4'hF, r);
         tk(3);
         chk(invalidreq, i == 1);
      end
      $display("test equalization done");
      wr(8'h40, 32'hFFFF_FFFF, 4'hF, r);
      chk(r, pipe_mac_pkg::RESP_SLVERR);
      rd(8'h40, d, r);
      chk({d, r}, {32'h0, pipe_mac_pkg::RESP_SLVERR});
      $display("test unmapped done");
      simu_mode_pipe <= 1'b1;
      wr(pipe_mac_pkg::SIM_OFS, 32'h23, 4'hF, r);
      tk(2);
      chk({sim_pipe_rate, sim_ltssmstate}, {pipe_mac_pkg::RATE_G3, 6'h23});
      simu_mode_pipe <= 1'b0;
      wr(pipe_mac_pkg::SIM_OFS, 32'h11, 4'hF, r);
      tk(2);
      chk(sim_ltssmstate, 6'h23);
      $display("test simulation mode done");
      give_verdict();
   end
endmodule
